// *** inc/capcmp_pkg.sv ***
// Shared constants and carrier types for the capture/compare timer unit.
package capcmp_pkg;
	// ------------------------------------------------------------------
	// Special function register addresses
	// ------------------------------------------------------------------
	localparam logic [7:0] ADDR_CONTROL   = 8'hea; // Timer control.
	localparam logic [7:0] ADDR_EDGE_CTL  = 8'heb; // Capture edge control.
	localparam logic [7:0] ADDR_FLAGS     = 8'hc8; // Interrupt flags.
	localparam logic [7:0] ADDR_SET_EN    = 8'hee; // Set enable, toggle state.
	localparam logic [7:0] ADDR_CLR_TGL   = 8'hef; // Clear/toggle enable.
	localparam logic [7:0] ADDR_PORT      = 8'hc0; // Output port.
	localparam logic [7:0] ADDR_COUNT_LO  = 8'hcc; // Live count, low byte.
	localparam logic [7:0] ADDR_COUNT_HI  = 8'hcd; // Live count, high byte.
	localparam logic [7:0] ADDR_CAP_BASE  = 8'hd0; // Capture n low at base+2n.
	localparam logic [7:0] ADDR_CMP_BASE  = 8'hd8; // Compare n low at base+2n.
	// ------------------------------------------------------------------
	// Field positions, codes and reset values
	// ------------------------------------------------------------------
	localparam int          FLAG_WIDE_BIT = 7;     // Wide overflow flag.
	localparam int          FLAG_CMP_LSB  = 4;     // Compare flags 6..4.
	localparam int          SET_TGL_LSB   = 6;     // Toggled port bits 7..6.
	localparam logic [1:0]  SRC_OFF       = 2'h0;  // Counter halted.
	localparam logic [1:0]  SRC_OSC       = 2'h1;  // Oscillator over twelve.
	localparam logic [1:0]  SRC_PIN       = 2'h3;  // External count pin.
	localparam logic [7:0]  RESET_BYTE    = 8'h00; // Reset of every byte-wide register.
	localparam logic [15:0] RESET_WORD    = 16'h0000;
	localparam logic [3:0]  OSC_DIV       = 4'hc;  // Oscillator prescale of twelve.
	// ------------------------------------------------------------------
	// Carrier types
	// ------------------------------------------------------------------
	typedef struct packed {
		logic       wide_overflow_irq_select; // Bit 7.
		logic       byte_overflow_irq_select; // Bit 6.
		logic       external_clear_enable;    // Bit 5.
		logic       byte_overflow_flag;       // Bit 4.
		logic [1:0] prescale_select;          // Bits 3..2.
		logic [1:0] source_select;            // Bits 1..0.
	} ctrl_t;
	typedef struct packed {
		logic       wr;    // Write strobe, one cycle.
		logic       rd;    // Read strobe, one cycle.
		logic [7:0] addr;  // Register address.
		logic [7:0] wdata; // Write data.
	} sfr_req_t;
endpackage

// *** src/pin_sync.sv ***
// Three-stage input synchroniser that accepts a level once two stages agree.
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 6
) (
	// Clock and reset.
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	input  wire logic         i_ce,
	// Raw pins and accepted levels.
	input  wire logic [W-1:0] i_pin,
	output logic      [W-1:0] o_level
);
	logic [W-1:0] s1_q; // Metastability catcher, read only by s2_q.
	logic [W-1:0] s2_q; // Second stage.
	logic [W-1:0] s3_q; // Third stage.

	// Shift the pins through three stages.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else if (i_ce) begin
			s1_q <= i_pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// A bit changes only once stages two and three agree, filtering glitches.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_level <= '0;
		end else if (i_ce) begin
			for (int i = 0; i < W; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					o_level[i] <= s3_q[i];
				end
			end
		end
	end
endmodule

// *** src/count_prescaler.sv ***
// Power-of-two prescaler between the count source and the timer.
`timescale 1ns/1ps
module count_prescaler (
	// Clock and reset.
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	input  wire logic       i_ce,
	// Control.
	input  wire logic       i_clr,
	input  wire logic       i_tick,
	input  wire logic [1:0] i_factor,
	// One-cycle pulse to the counter.
	output logic            o_pulse
);
	logic [2:0] cnt_q; // Ticks seen since the last pulse.

	// Terminal count for a division of 1, 2, 4 or 8.
	function automatic logic [2:0] last_count(input logic [1:0] f);
		last_count = 3'((4'h1 << f) - 4'h1);
	endfunction

	// Count ticks; clearing drops any partial period.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt_q   <= 3'h0;
			o_pulse <= 1'b0;
		end else if (i_ce) begin
			o_pulse <= 1'b0;
			if (i_clr) begin
				cnt_q <= 3'h0;
			end else if (i_tick) begin
				if (cnt_q >= last_count(i_factor)) begin
					cnt_q   <= 3'h0;
					o_pulse <= 1'b1;
				end else begin
					cnt_q <= cnt_q + 3'h1;
				end
			end
		end
	end

	presc_clear_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_ce && i_clr |=> cnt_q == 3'h0 && !o_pulse)
		else $error("prescaler not cleared");
endmodule

// *** src/timer_capture_compare_unit.sv ***
// Sixteen-bit timer with four capture and three compare channels.
//
// Contract
// - Prescaler divides by 1, 2, 4, 8.
// - Sources: oscillator over twelve, pin, off.
// - Source codes 00 off, 01 osc, 11 pin.
// - Prescaler cleared on field change or reset.
// - Count readable live; software guards carries.
// - Count unwritable; cleared by reset, clear pin.
// - Idle holds counter and prescaler cleared.
// - Selected capture edge latches count, flags.
// - Rising, falling or both; none disables.
// - Three compares match continuously, raising flags.
// - Compare zero sets enabled port bits 0-5.
// - Compare one clears enabled port bits 0-5.
// - Compare two toggles enabled port bits 6-7.
// - Compare registers cleared on reset.
// - Software port access coexists with matches.
// - Byte and wide overflow share one request.
// - Control bits: 7, 6 selects, 4 flag.
// - Flags only cleared by software writes.
// - Edge control: falling 2n+1, rising 2n.
// - Flags: wide 7, compare 6-4, capture 3-0.
// - Set-enable bits 7-6 show toggle state.
`timescale 1ns/1ps
module timer_capture_compare_unit (
	// Clock, reset and clock enable.
	input  wire logic                 i_clk,
	input  wire logic                 i_rst,
	input  wire logic                 i_ce,
	// Power mode.
	input  wire logic                 i_idle,
	// Register port.
	input  wire capcmp_pkg::sfr_req_t i_sfr,
	output logic [7:0]                o_rdata,
	// External pins.
	input  wire logic [3:0]           i_capture_in,
	input  wire logic                 i_count_pin,
	input  wire logic                 i_timer_clear_pin,
	// Output port and interrupt requests.
	output logic [7:0]                o_port,
	output logic [7:0]                o_irq_flags,
	output logic                      o_overflow_irq
);
	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	capcmp_pkg::ctrl_t ctrl_q;        // Timer control register.
	capcmp_pkg::ctrl_t ctrl_prev_q;   // Last cycle's control, for change detect.
	logic [7:0]        edge_ctl_q;    // Capture edge enables.
	logic [7:0]        set_en_q;      // Set enables; bits 7..6 unused here.
	logic [7:0]        clr_tgl_q;     // Clear and toggle enables.
	logic [15:0]       count_q;       // Free-running count.
	logic [15:0]       cap_q [4];     // Capture registers.
	logic [15:0]       cmp_q [3];     // Compare registers.
	logic [3:0]        osc_div_q;     // Oscillator divide-by-twelve counter.
	logic [5:0]        lvl_prev_q;    // Accepted pin levels, one cycle old.
	logic [5:0]        lvl;           // Accepted pin levels.
	logic              presc_pulse;   // Count enable from the prescaler.

	// ------------------------------------------------------------------
	// Combinational events
	// ------------------------------------------------------------------
	logic        osc_tick;   // One cycle in twelve.
	logic        pin_rise;   // Count pin rising edge.
	logic        clear_rise; // Clear pin rising edge.
	logic        cnt_clear;  // Counter cleared this cycle.
	logic        presc_clr;  // Prescaler cleared this cycle.
	logic        inc;        // Counter increments this cycle.
	logic [15:0] count_nxt;  // Incremented count.
	logic [2:0]  match;      // Compare match pulses.
	logic [3:0]  cap_evt;    // Capture events.
	logic        wide_ovf;   // Wrap of all sixteen bits.
	logic        byte_ovf;   // Wrap of the low byte.
	logic        wr_port;    // Software write to the port.

	// Decode a write strobe to one address.
	function automatic logic wr_to(input capcmp_pkg::sfr_req_t r, input logic [7:0] a);
		wr_to = r.wr && (r.addr == a);
	endfunction

	// ------------------------------------------------------------------
	// Pin synchronisation
	// ------------------------------------------------------------------
	pin_sync #(
		.W (6)
	) u_sync (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_ce    (i_ce),
		.i_pin   ({i_timer_clear_pin, i_count_pin, i_capture_in}),
		.o_level (lvl)
	);

	// Keep the previous accepted levels for edge detection.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			lvl_prev_q <= 6'h00;
		end else if (i_ce) begin
			lvl_prev_q <= lvl;
		end
	end

	// ------------------------------------------------------------------
	// Count source and prescaler
	// ------------------------------------------------------------------
	// Derive events; the test source code is treated as off, so it cannot
	// run the counter by accident.
	always_comb begin
		osc_tick   = (osc_div_q == capcmp_pkg::OSC_DIV - 4'h1);
		pin_rise   = lvl[4] && !lvl_prev_q[4];
		clear_rise = lvl[5] && !lvl_prev_q[5];
		cnt_clear  = i_idle || (clear_rise && ctrl_q.external_clear_enable);
		presc_clr  = cnt_clear
			|| (ctrl_q.prescale_select != ctrl_prev_q.prescale_select)
			|| (ctrl_q.source_select != ctrl_prev_q.source_select);
		inc        = presc_pulse && !cnt_clear;
		count_nxt  = count_q + 16'h0001;
		wide_ovf   = inc && (count_q == 16'hffff);
		byte_ovf   = inc && (count_q[7:0] == 8'hff);
		wr_port    = wr_to(i_sfr, capcmp_pkg::ADDR_PORT);
		for (int i = 0; i < 3; i++) begin
			match[i] = inc && (count_nxt == cmp_q[i]);
		end
		for (int n = 0; n < 4; n++) begin
			cap_evt[n] = (edge_ctl_q[2*n] && lvl[n] && !lvl_prev_q[n])
				|| (edge_ctl_q[2*n+1] && !lvl[n] && lvl_prev_q[n]);
		end
	end

	// Divide the clock by twelve; held in step while idle.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			osc_div_q <= 4'h0;
		end else if (i_ce) begin
			osc_div_q <= (osc_tick || i_idle) ? 4'h0 : osc_div_q + 4'h1;
		end
	end

	// Selected source feeds the prescaler.
	logic presc_tick; // Tick into the prescaler.
	always_comb begin
		unique case (ctrl_q.source_select)
			capcmp_pkg::SRC_OSC: presc_tick = osc_tick;
			capcmp_pkg::SRC_PIN: presc_tick = pin_rise;
			default:             presc_tick = 1'b0;
		endcase
	end

	count_prescaler u_presc (
		.i_clk    (i_clk),
		.i_rst    (i_rst),
		.i_ce     (i_ce),
		.i_clr    (presc_clr),
		.i_tick   (presc_tick),
		.i_factor (ctrl_q.prescale_select),
		.o_pulse  (presc_pulse)
	);

	// ------------------------------------------------------------------
	// Counter and captures
	// ------------------------------------------------------------------
	// The counter has no write path; software can only watch it.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			count_q <= capcmp_pkg::RESET_WORD;
		end else if (i_ce) begin
			if (cnt_clear) begin
				count_q <= capcmp_pkg::RESET_WORD;
			end else if (inc) begin
				count_q <= count_nxt;
			end
		end
	end

	// Latch the count present at the qualified edge.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			for (int n = 0; n < 4; n++) begin
				cap_q[n] <= capcmp_pkg::RESET_WORD;
			end
		end else if (i_ce) begin
			for (int n = 0; n < 4; n++) begin
				if (cap_evt[n]) begin
					cap_q[n] <= count_q;
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Software-written registers
	// ------------------------------------------------------------------
	// Control, edge, enable and compare registers; the byte overflow flag
	// accepts software writes but a hardware set in the same cycle wins.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ctrl_q      <= capcmp_pkg::ctrl_t'(capcmp_pkg::RESET_BYTE);
			ctrl_prev_q <= capcmp_pkg::ctrl_t'(capcmp_pkg::RESET_BYTE);
			edge_ctl_q  <= capcmp_pkg::RESET_BYTE;
			set_en_q    <= capcmp_pkg::RESET_BYTE;
			clr_tgl_q   <= capcmp_pkg::RESET_BYTE;
			for (int i = 0; i < 3; i++) begin
				cmp_q[i] <= capcmp_pkg::RESET_WORD;
			end
		end else if (i_ce) begin
			ctrl_prev_q <= ctrl_q;
			if (wr_to(i_sfr, capcmp_pkg::ADDR_CONTROL)) begin
				ctrl_q <= capcmp_pkg::ctrl_t'(i_sfr.wdata);
			end
			if (byte_ovf) begin
				ctrl_q.byte_overflow_flag <= 1'b1;
			end
			if (wr_to(i_sfr, capcmp_pkg::ADDR_EDGE_CTL)) begin
				edge_ctl_q <= i_sfr.wdata;
			end
			if (wr_to(i_sfr, capcmp_pkg::ADDR_SET_EN)) begin
				set_en_q <= i_sfr.wdata;
			end
			if (wr_to(i_sfr, capcmp_pkg::ADDR_CLR_TGL)) begin
				clr_tgl_q <= i_sfr.wdata;
			end
			for (int i = 0; i < 3; i++) begin
				if (wr_to(i_sfr, capcmp_pkg::ADDR_CMP_BASE + 8'(2 * i))) begin
					cmp_q[i][7:0] <= i_sfr.wdata;
				end
				if (wr_to(i_sfr, capcmp_pkg::ADDR_CMP_BASE + 8'(2 * i + 1))) begin
					cmp_q[i][15:8] <= i_sfr.wdata;
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Interrupt flags and request
	// ------------------------------------------------------------------
	// Hardware only sets; a software write in the same cycle loses to a set.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_irq_flags    <= capcmp_pkg::RESET_BYTE;
			o_overflow_irq <= 1'b0;
		end else if (i_ce) begin
			o_irq_flags <= (wr_to(i_sfr, capcmp_pkg::ADDR_FLAGS) ? i_sfr.wdata : o_irq_flags)
				| {wide_ovf, match, cap_evt};
			o_overflow_irq <= (ctrl_q.wide_overflow_irq_select && o_irq_flags[7])
				|| (ctrl_q.byte_overflow_irq_select && ctrl_q.byte_overflow_flag);
		end
	end

	// ------------------------------------------------------------------
	// Output port
	// ------------------------------------------------------------------
	// Software write is applied first, then the match actions on top, so both
	// take effect in one cycle; a clear on the same count beats a set.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_port <= capcmp_pkg::RESET_BYTE;
		end else if (i_ce) begin
			logic [7:0] p;
			p = wr_port ? i_sfr.wdata : o_port;
			if (match[0]) begin
				p[5:0] = p[5:0] | set_en_q[5:0];
			end
			if (match[1]) begin
				p[5:0] = p[5:0] & ~clr_tgl_q[5:0];
			end
			if (match[2]) begin
				p[7:6] = p[7:6] ^ clr_tgl_q[7:6];
			end
			o_port <= p;
		end
	end

	// ------------------------------------------------------------------
	// Register read port
	// ------------------------------------------------------------------
	// Count bytes come straight from the counter: no shadow copy is taken, so
	// a carry between two byte reads is the reader's problem.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rdata <= capcmp_pkg::RESET_BYTE;
		end else if (i_ce && i_sfr.rd) begin
			o_rdata <= 8'h00;
			unique case (i_sfr.addr)
				capcmp_pkg::ADDR_CONTROL:  o_rdata <= ctrl_q;
				capcmp_pkg::ADDR_EDGE_CTL: o_rdata <= edge_ctl_q;
				capcmp_pkg::ADDR_FLAGS:    o_rdata <= o_irq_flags;
				capcmp_pkg::ADDR_SET_EN:   o_rdata <= {o_port[7:6], set_en_q[5:0]};
				capcmp_pkg::ADDR_CLR_TGL:  o_rdata <= clr_tgl_q;
				capcmp_pkg::ADDR_PORT:     o_rdata <= o_port;
				capcmp_pkg::ADDR_COUNT_LO: o_rdata <= count_q[7:0];
				capcmp_pkg::ADDR_COUNT_HI: o_rdata <= count_q[15:8];
				default: begin
					for (int n = 0; n < 4; n++) begin
						if (i_sfr.addr == capcmp_pkg::ADDR_CAP_BASE + 8'(2 * n)) begin
							o_rdata <= cap_q[n][7:0];
						end
						if (i_sfr.addr == capcmp_pkg::ADDR_CAP_BASE + 8'(2 * n + 1)) begin
							o_rdata <= cap_q[n][15:8];
						end
					end
					for (int i = 0; i < 3; i++) begin
						if (i_sfr.addr == capcmp_pkg::ADDR_CMP_BASE + 8'(2 * i)) begin
							o_rdata <= cmp_q[i][7:0];
						end
						if (i_sfr.addr == capcmp_pkg::ADDR_CMP_BASE + 8'(2 * i + 1)) begin
							o_rdata <= cmp_q[i][15:8];
						end
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	idle_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_ce && i_idle [*2] |-> count_q == 16'h0000 && !presc_pulse)
		else $error("count moved in idle");
	ext_clear_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_ce && clear_rise && ctrl_q.external_clear_enable |=> count_q == 16'h0000)
		else $error("clear pin ignored");
	count_step_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_ce && inc |=> count_q == $past(count_q) + 16'h0001)
		else $error("count did not step");
	count_still_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_ce && !cnt_clear && ctrl_q.source_select == capcmp_pkg::SRC_OFF
		&& ctrl_prev_q.source_select == capcmp_pkg::SRC_OFF [*2] |=> $stable(count_q))
		else $error("halted counter moved");
	capture_load_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_ce && cap_evt[0] |=> cap_q[0] == $past(count_q) && o_irq_flags[0])
		else $error("capture missed");
	capture_off_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_ce && edge_ctl_q[1:0] == 2'h0 |=> $stable(cap_q[0]))
		else $error("disabled capture fired");
	wide_flag_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_ce && wide_ovf |=> o_irq_flags[capcmp_pkg::FLAG_WIDE_BIT] [*1])
		else $error("overflow flag lost");
	set_port_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_ce && match[0] && !match[1] |=> (o_port[5:0] & $past(set_en_q[5:0]))
		== $past(set_en_q[5:0]))
		else $error("set action missed");
	toggle_port_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_ce && match[2] && clr_tgl_q[7] && !wr_port |=> o_port[7] != $past(o_port[7]))
		else $error("toggle action missed");
	ovf_irq_a: assert property (@(posedge i_clk) disable iff (i_rst)
		i_ce && ctrl_q.byte_overflow_irq_select && ctrl_q.byte_overflow_flag |=> o_overflow_irq)
		else $error("overflow request missing");
endmodule

// *** tb/ext_pins.sv ***
// Model of the pins around the timer: capture inputs, count pin and clear pin.
`timescale 1ns/1ps
module ext_pins (
	// Clock used to pace the pin activity.
	input  wire logic       i_clk,
	// Pins driven towards the timer block.
	output logic      [3:0] o_capture_in,
	output logic            o_count_pin,
	output logic            o_timer_clear_pin
);
	// All pins start low so that no edge is seen at reset release.
	initial begin
		o_capture_in      = 4'h0;
		o_count_pin       = 1'b0;
		o_timer_clear_pin = 1'b0;
	end

	// Each level is held four cycles, well past the two-stage filter.
	// Spacing the edges wider than two cycles keeps every edge visible.
	task automatic count_edges(input int n);
		for (int k = 0; k < n; k++) begin
			@(posedge i_clk);
			#1 o_count_pin = 1'b1;
			repeat (4) @(posedge i_clk);
			#1 o_count_pin = 1'b0;
			repeat (4) @(posedge i_clk);
		end
	endtask

	// Moves one capture input to a new level and lets it settle.
	task automatic set_capture(input int idx, input logic lvl);
		@(posedge i_clk);
		#1 o_capture_in[idx] = lvl;
		repeat (8) @(posedge i_clk);
	endtask

	// A single high pulse on the clear pin; only its rising edge matters.
	task automatic clear_pulse();
		@(posedge i_clk);
		#1 o_timer_clear_pin = 1'b1;
		repeat (4) @(posedge i_clk);
		#1 o_timer_clear_pin = 1'b0;
		repeat (4) @(posedge i_clk);
	endtask
endmodule

// *** tb/tb_timer_capture_compare_unit.sv ***
// Self-checking testbench for the capture/compare timer unit.
`timescale 1ns/1ps
module tb_timer_capture_compare_unit;
	logic                 i_clk;             // 125 MHz clock.
	logic                 i_rst;             // Asynchronous reset.
	logic                 i_idle;            // Idle mode request.
	logic                 ce;                // Clock enable, low freezes the block.
	capcmp_pkg::sfr_req_t sfr;               // Register request.
	logic           [7:0] o_rdata;           // Read data.
	logic           [3:0] cap_in;            // Capture pins.
	logic                 count_pin;         // External count pin.
	logic                 clear_pin;         // External clear pin.
	logic           [7:0] o_port;            // Output port.
	logic           [7:0] o_irq_flags;       // Flag register.
	logic                 o_overflow_irq;    // Overflow request.
	int                   err_count;         // Mismatches seen.
	int                   tests_run;         // Comparisons made.
	int                   cycles;            // Timeout counter.

	// ------------------------------------------------------------------
	// Clock, devices and timeout
	// ------------------------------------------------------------------
	initial i_clk = 1'b0;
	always #4 i_clk = ~i_clk;

	timer_capture_compare_unit u_timer_capture_compare_unit (
		.i_clk(i_clk), .i_rst(i_rst), .i_ce(ce), .i_idle(i_idle), .i_sfr(sfr),
		.o_rdata(o_rdata), .i_capture_in(cap_in), .i_count_pin(count_pin),
		.i_timer_clear_pin(clear_pin), .o_port(o_port), .o_irq_flags(o_irq_flags),
		.o_overflow_irq(o_overflow_irq));

	ext_pins u_ext_pins (
		.i_clk(i_clk), .o_capture_in(cap_in), .o_count_pin(count_pin),
		.o_timer_clear_pin(clear_pin));

	// The whole sequence needs about 3500 cycles; the ceiling leaves ample room.
	always @(posedge i_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_count++;
			final_report();
		end
	end

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string name);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Write strobe is held for exactly one taken edge.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		#1 sfr = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge i_clk);
		#1 sfr.wr = 1'b0;
	endtask

	// Read data is registered at the taken edge, so it is sampled just after it.
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
		@(posedge i_clk);
		#1 sfr = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge i_clk);
		#1 sfr.rd = 1'b0;
		check(o_rdata, exp, name);
	endtask

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		err_count = 0;
		tests_run = 0;
		cycles    = 0;
		i_rst     = 1'b1;
		i_idle    = 1'b0;
		ce        = 1'b1;
		sfr       = '0;
		repeat (5) @(posedge i_clk);
		#1 i_rst = 1'b0;

		// Reset state, including a compare register and an unmapped place.
		rd(capcmp_pkg::ADDR_CONTROL, 8'h00, "control");
		rd(capcmp_pkg::ADDR_FLAGS, 8'h00, "flags");
		rd(capcmp_pkg::ADDR_CMP_BASE, 8'h00, "cmp0 low");
		rd(8'ha0, 8'h00, "unmapped");

		// Count pin edges with prescale of one, then of two.
		wr(capcmp_pkg::ADDR_CONTROL, 8'h03);
		u_ext_pins.count_edges(5);
		rd(capcmp_pkg::ADDR_COUNT_LO, 8'h05, "count pin x1");
		wr(capcmp_pkg::ADDR_CONTROL, 8'h07);
		u_ext_pins.count_edges(4);
		rd(capcmp_pkg::ADDR_COUNT_LO, 8'h07, "count pin x2");
		rd(capcmp_pkg::ADDR_COUNT_HI, 8'h00, "count high");

		// Capture on rising edge only, then on both edges of input three.
		wr(capcmp_pkg::ADDR_EDGE_CTL, 8'h01);
		u_ext_pins.set_capture(0, 1'b1);
		rd(capcmp_pkg::ADDR_CAP_BASE, 8'h07, "capture 0");
		rd(capcmp_pkg::ADDR_FLAGS, 8'h01, "capture flag");
		wr(capcmp_pkg::ADDR_FLAGS, 8'h00);
		u_ext_pins.set_capture(0, 1'b0);
		rd(capcmp_pkg::ADDR_FLAGS, 8'h00, "no fall edge");
		wr(capcmp_pkg::ADDR_EDGE_CTL, 8'hc0);
		u_ext_pins.set_capture(3, 1'b1);
		u_ext_pins.set_capture(3, 1'b0);
		rd(capcmp_pkg::ADDR_FLAGS, 8'h08, "both edges in3");
		wr(capcmp_pkg::ADDR_FLAGS, 8'h00);

		// Count cannot be written; the clear pin zeroes it when enabled.
		wr(capcmp_pkg::ADDR_COUNT_LO, 8'h55);
		rd(capcmp_pkg::ADDR_COUNT_LO, 8'h07, "count write");
		wr(capcmp_pkg::ADDR_CONTROL, 8'h23);
		u_ext_pins.clear_pulse();
		rd(capcmp_pkg::ADDR_COUNT_LO, 8'h00, "clear pin");

		// Compare channels set, toggle and clear port bits step by step.
		wr(capcmp_pkg::ADDR_CMP_BASE, 8'h03);
		wr(capcmp_pkg::ADDR_CMP_BASE + 8'h02, 8'h05);
		wr(capcmp_pkg::ADDR_CMP_BASE + 8'h04, 8'h04);
		wr(capcmp_pkg::ADDR_SET_EN, 8'h01);
		wr(capcmp_pkg::ADDR_CLR_TGL, 8'h81);
		u_ext_pins.count_edges(3);
		check(o_port, 8'h01, "port set");
		u_ext_pins.count_edges(1);
		check(o_port, 8'h81, "port toggle");
		rd(capcmp_pkg::ADDR_SET_EN, 8'h81, "toggle state");
		u_ext_pins.count_edges(1);
		check(o_port, 8'h80, "port clear");
		check(o_irq_flags, 8'h70, "compare flags");
		wr(capcmp_pkg::ADDR_PORT, 8'h06);
		rd(capcmp_pkg::ADDR_PORT, 8'h06, "port write");

		// With the clock enable low, count pin edges must leave the count alone.
		@(posedge i_clk);
		#1 ce = 1'b0;
		u_ext_pins.count_edges(2);
		#1 ce = 1'b1;
		rd(capcmp_pkg::ADDR_COUNT_LO, 8'h05, "ce frozen");

		// Oscillator source until the low byte wraps.
		wr(capcmp_pkg::ADDR_CONTROL, 8'h41);
		repeat (3200) @(posedge i_clk);
		rd(capcmp_pkg::ADDR_CONTROL, 8'h51, "byte overflow");
		check({7'h00, o_overflow_irq}, 8'h01, "overflow irq");
		wr(capcmp_pkg::ADDR_CONTROL, 8'h40);
		repeat (2) @(posedge i_clk);
		check({7'h00, o_overflow_irq}, 8'h00, "irq cleared");

		// Idle clears and holds the count.
		#1 i_idle = 1'b1;
		repeat (3) @(posedge i_clk);
		rd(capcmp_pkg::ADDR_COUNT_LO, 8'h00, "idle low");
		rd(capcmp_pkg::ADDR_COUNT_HI, 8'h00, "idle high");
		final_report();
	end
endmodule
